// *** afq_drive_model.sv ***
// Behavioural model of the drive's encoder input and its zero-reference strobe.
// Assumes the converter's registered encoder channels on the same system clock.
`timescale 1ns/1ps
`default_nettype none
module afq_drive_model
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic pressure_reached_in,
  input wire logic driving_in,
  output logic zero_reference_strobe_out,
  output logic drive_release_input_out,
  output var int position_out,
  output logic encoder_error_out
);
  // ****************************************************************
  // Strobe sequencing and quadrature decoding
  // ****************************************************************
  logic a_q;
  logic b_q;
  logic press_q;
  logic drv_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      press_q <= 1'b0;
      drv_q <= 1'b0;
      zero_reference_strobe_out <= 1'b1;
      drive_release_input_out <= 1'b0;
      position_out <= 0;
      encoder_error_out <= 1'b0;
    end
    else
    begin
      a_q <= enc_a_in;
      b_q <= enc_b_in;
      press_q <= pressure_reached_in;
      drv_q <= driving_in;
      drive_release_input_out <= driving_in;
      if (pressure_reached_in && !press_q)
        zero_reference_strobe_out <= 1'b0;
      if (driving_in && !drv_q)
        zero_reference_strobe_out <= 1'b1;
      // A step that moves both channels at once cannot come from a live encoder.
      if (a_q != enc_a_in && b_q != enc_b_in)
        encoder_error_out <= 1'b1;
      else if (a_q != enc_a_in)
        position_out <= position_out + ((enc_a_in != enc_b_in) ? 1 : -1);
      else if (b_q != enc_b_in)
        position_out <= position_out + ((enc_a_in == enc_b_in) ? 1 : -1);
    end
  end
endmodule
`default_nettype wire

// *** afq_pkg.sv ***
// Shared constants of the flow-to-quadrature level converter.
// Assumes a 200 MHz system clock and a sensor current sampled in microamps.
package afq_pkg;

  // ****************************************************************
  // Clock and times
  // ****************************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HOLD_MS = 2000;
  localparam int unsigned RAMP_MS = 1000;
  localparam int unsigned BLANK_MS = 1000;
  localparam int unsigned STOP_MS = 50;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * CYC_PER_MS;
  localparam int unsigned BLANK_CYCLES = BLANK_MS * CYC_PER_MS;
  localparam int unsigned STOP_CYCLES = STOP_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYCLES = FLASH_MS * CYC_PER_MS;
  localparam int unsigned RAMP_SHIFT = 10;
  localparam int unsigned RAMP_STEPS = 1 << RAMP_SHIFT;
  localparam int unsigned STEP_CYCLES = RAMP_MS * CYC_PER_MS / RAMP_STEPS;

  // ****************************************************************
  // Counter widths
  // ****************************************************************
  localparam int HOLD_W = 29;
  localparam int BLANK_W = 28;
  localparam int STOP_W = 24;
  localparam int STEP_W = 18;
  localparam int FLASH_W = 26;
  localparam int REM_W = 11;

  // ****************************************************************
  // Sensor current thresholds in microamps
  // ****************************************************************
  localparam int CUR_W = 16;
  localparam logic [15:0] RANGE_MIN_UA = 16'h0fa0;
  localparam logic [15:0] RANGE_MAX_UA = 16'h4e20;
  localparam logic [15:0] STOP1_MIN_UA = 16'h1a90;
  localparam logic [15:0] STOP1_MAX_UA = 16'h41a0;
  localparam logic [15:0] STOP2_MIN_UA = 16'h138d;
  localparam logic [15:0] STOP2_MAX_UA = 16'h4a06;
  localparam logic [15:0] STILL_MIN_UA = 16'h2cec;
  localparam logic [15:0] STILL_MAX_UA = 16'h30d4;
  localparam logic [15:0] ZERO_MIN_UA = 16'h2e7c;
  localparam logic [15:0] ZERO_MAX_UA = 16'h2f44;
  localparam logic [15:0] ZERO_REF_UA = 16'h2ee0;

  // ****************************************************************
  // Frequency synthesis
  // ****************************************************************
  localparam logic signed [23:0] BASE_HZ = 24'sh00001e;
  localparam logic [23:0] MAX_HZ = 24'h007530;
  localparam int GAIN_MUL = 15;
  localparam int GAIN_SHIFT = 2;
  localparam int INC_SHIFT = 8;
  localparam longint INC_PER_HZ = ((64'd1 << 40) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [12:0] INC_MUL = 13'(INC_PER_HZ);

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_REF = 4'h2;
  localparam logic [3:0] REG_CURRENT = 4'h3;
  localparam int ST_W = 4;
  localparam int ST_RANGE = 0;
  localparam int ST_STOP = 1;
  localparam int ST_STILL = 2;
  localparam int ST_REF = 3;

  // ****************************************************************
  // Synchronised pin positions
  // ****************************************************************
  localparam int PIN_W = 6;
  localparam int PIN_MODE = 0;
  localparam int PIN_LIMIT = 1;
  localparam int PIN_STROBE = 2;
  localparam int PIN_RELEASE = 3;
  localparam int PIN_TA = 4;
  localparam int PIN_TB = 5;

endpackage

// *** afq_sync.sv ***
// Three-stage synchroniser for the asynchronous pins of the converter.
// Assumes slow, quasi-static pins; a change counts when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module afq_sync
  import afq_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [afq_pkg::PIN_W-1:0] pins_in,
  output logic [afq_pkg::PIN_W-1:0] pins_out
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] o;
  } afq_sync_type;

  afq_sync_type q;
  afq_sync_type d;
  logic [PIN_W-1:0] agree;

  // Stage one is read only by stage two, so no gate sees a metastable value.
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_bit
      assign agree[i] = ~(q.s2[i] ^ q.s3[i]);
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.o = (agree & q.s2) | (~agree & q.o);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      q <= '0;
    else if (ce_in)
      q <= d;
  end

  assign pins_out = q.o;
endmodule
`default_nettype wire

// *** afq_top.sv ***
// Flow sensor to quadrature encoder converter with supervision.
// Assumes the sensor current arrives on the system clock in microamps.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Jumper closed selects analogue mode, open selects turbine mode.
// - Turbine mode passes both turbine channels unchanged to encoder outputs.
// - Analogue mode makes a quadrature signal of either direction, at most 30 kHz.
// - At the reference current a 30 Hz positive-direction signal is produced.
// - Falling zero-reference strobe edge captures current value as new reference.
// - After capture wait 2 s, then remove old/new difference over 1 s.
// - Analogue supervision is always active and cannot be disabled.
// - Current below 4 mA or above 20 mA blanks encoder outputs 1 s.
// - Out-of-range fault shows steady red on the indicator.
// - Limit jumper open gives stop limits 6.8 mA and 16.8 mA.
// - Limit jumper closed gives stop limits 5.005 mA and 18.950 mA.
// - Stop limit held 0.05 s flags error, blanks 1 s, steady red.
// - While driving, current outside 11.5..12.5 mA blanks 1 s, flashes red/blue.
// - Blue indicator shows sensor at its zero position.
module afq_top
  import afq_pkg::*;
#(
  parameter int unsigned HOLD_CYC = afq_pkg::HOLD_CYCLES,
  parameter int unsigned STEP_CYC = afq_pkg::STEP_CYCLES,
  parameter int unsigned BLANK_CYC = afq_pkg::BLANK_CYCLES,
  parameter int unsigned STOP_CYC = afq_pkg::STOP_CYCLES,
  parameter int unsigned FLASH_CYC = afq_pkg::FLASH_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic mode_select_jumper_in,
  input wire logic stop_limit_jumper_in,
  input wire logic zero_reference_strobe_in,
  input wire logic drive_release_input_in,
  input wire logic turbine_a_in,
  input wire logic turbine_b_in,
  input wire logic [afq_pkg::CUR_W-1:0] sensor_current_in,
  input wire logic [afq_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [afq_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [afq_pkg::DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  output logic enc_a_out,
  output logic enc_b_out,
  output logic monitor_indicator_red_out,
  output logic monitor_indicator_blue_out
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] phase;
    logic [CUR_W-1:0] ref_v;
    logic signed [16:0] corr0;
    logic [REM_W-1:0] rem;
    logic [HOLD_W-1:0] hold_cnt;
    logic [STEP_W-1:0] step_cnt;
    logic [BLANK_W-1:0] blank_cnt;
    logic [STOP_W-1:0] stop_cnt;
    logic [FLASH_W-1:0] flash_cnt;
    logic flash;
    logic flash_cause;
    logic strobe_prev;
    logic enc_a;
    logic enc_b;
    logic led_red;
    logic led_blue;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
  } afq_state_type;

  afq_state_type q;
  afq_state_type d;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic analog_mode;
  logic fall;
  logic range_f;
  logic stop_hit;
  logic stop_f;
  logic still_f;
  logic any_f;
  logic blanking;
  logic signed [28:0] corr_now;
  logic signed [17:0] eff_ref;
  logic signed [18:0] dev;
  logic signed [23:0] hz_raw;
  logic [23:0] hz_mag;
  logic [14:0] hz_clip;
  logic [27:0] inc_raw;
  logic [31:0] inc;
  logic [15:0] stop_min;
  logic [15:0] stop_max;

  assign pins_raw = {turbine_b_in, turbine_a_in, drive_release_input_in,
                     zero_reference_strobe_in, stop_limit_jumper_in,
                     mode_select_jumper_in};

  afq_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  // ****************************************************************
  // Supervision and frequency terms
  // ****************************************************************
  // A high jumper pin means the jumper is closed.
  assign analog_mode = pins_s[PIN_MODE];
  assign fall = q.strobe_prev & ~pins_s[PIN_STROBE];
  assign stop_min = pins_s[PIN_LIMIT] ? STOP2_MIN_UA : STOP1_MIN_UA;
  assign stop_max = pins_s[PIN_LIMIT] ? STOP2_MAX_UA : STOP1_MAX_UA;

  // Supervision depends on no software setting at all.
  assign range_f = analog_mode &&
                   (sensor_current_in < RANGE_MIN_UA || sensor_current_in > RANGE_MAX_UA);
  assign stop_hit = analog_mode &&
                    (sensor_current_in <= stop_min || sensor_current_in >= stop_max);
  assign stop_f = stop_hit && (q.stop_cnt == STOP_W'(STOP_CYC - 1));
  assign still_f = analog_mode && pins_s[PIN_RELEASE] &&
                   (sensor_current_in < STILL_MIN_UA || sensor_current_in > STILL_MAX_UA);
  assign any_f = range_f | stop_f | still_f;
  assign blanking = (q.blank_cnt != '0);

  // The correction keeps the old reference in force and fades it linearly.
  assign corr_now = (29'(q.corr0) * $signed({18'h0, q.rem})) >>> RAMP_SHIFT;
  assign eff_ref = $signed({2'b00, q.ref_v}) + 18'(corr_now);
  assign dev = $signed({3'b000, sensor_current_in}) - 19'(eff_ref);
  assign hz_raw = BASE_HZ + ((24'(dev) * 24'(GAIN_MUL)) >>> GAIN_SHIFT);
  assign hz_mag = hz_raw[23] ? 24'(-hz_raw) : 24'(hz_raw);
  assign hz_clip = (hz_mag > MAX_HZ) ? MAX_HZ[14:0] : hz_mag[14:0];
  assign inc_raw = 28'({13'h0, hz_clip} * {15'h0, INC_MUL});
  assign inc = {12'h000, inc_raw[27:INC_SHIFT]};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    d.strobe_prev = pins_s[PIN_STROBE];

    // Negative frequency steps the phase backwards, so B leads A.
    if (hz_raw[23])
      d.phase = q.phase - inc;
    else
      d.phase = q.phase + inc;

    if (fall)
    begin
      d.ref_v = sensor_current_in;
      d.corr0 = 17'(eff_ref - $signed({2'b00, sensor_current_in}));
      d.rem = REM_W'(RAMP_STEPS);
      d.hold_cnt = HOLD_W'(HOLD_CYC);
      d.step_cnt = '0;
    end
    else if (q.hold_cnt != '0)
      d.hold_cnt = q.hold_cnt - 1'b1;
    else if (q.rem != '0)
    begin
      if (q.step_cnt == STEP_W'(STEP_CYC - 1))
      begin
        d.step_cnt = '0;
        d.rem = q.rem - 1'b1;
      end
      else
        d.step_cnt = q.step_cnt + 1'b1;
    end

    if (!stop_hit)
      d.stop_cnt = '0;
    else if (!stop_f)
      d.stop_cnt = q.stop_cnt + 1'b1;

    // Every fresh fault reloads the full blanking time.
    if (any_f)
    begin
      d.blank_cnt = BLANK_W'(BLANK_CYC);
      d.flash_cause = ~(range_f | stop_f) & still_f;
    end
    else if (blanking)
      d.blank_cnt = q.blank_cnt - 1'b1;

    if (q.flash_cnt == FLASH_W'(FLASH_CYC - 1))
    begin
      d.flash_cnt = '0;
      d.flash = ~q.flash;
    end
    else
      d.flash_cnt = q.flash_cnt + 1'b1;

    if (d.blank_cnt != '0)
    begin
      d.enc_a = 1'b0;
      d.enc_b = 1'b0;
    end
    else if (analog_mode)
    begin
      d.enc_a = d.phase[31] ^ d.phase[30];
      d.enc_b = d.phase[31];
    end
    else
    begin
      d.enc_a = pins_s[PIN_TA];
      d.enc_b = pins_s[PIN_TB];
    end

    if (d.blank_cnt != '0)
    begin
      d.led_red = d.flash_cause ? q.flash : 1'b1;
      d.led_blue = d.flash_cause & ~q.flash;
    end
    else
    begin
      d.led_red = 1'b0;
      d.led_blue = analog_mode && sensor_current_in > ZERO_MIN_UA &&
                   sensor_current_in < ZERO_MAX_UA;
    end

    // A read clears the status, but an event in the same cycle survives.
    if (reg_rd_in && reg_addr_in == REG_STATUS)
      d.status = '0;
    d.status[ST_RANGE] = d.status[ST_RANGE] | range_f;
    d.status[ST_STOP] = d.status[ST_STOP] | stop_f;
    d.status[ST_STILL] = d.status[ST_STILL] | still_f;
    d.status[ST_REF] = d.status[ST_REF] | fall;

    if (reg_wr_in && reg_addr_in == REG_MASK)
      d.mask = reg_wdata_in[ST_W-1:0];

    d.rdata = '0;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        REG_STATUS: d.rdata = {12'h000, q.status};
        REG_MASK: d.rdata = {12'h000, q.mask};
        REG_REF: d.rdata = q.ref_v;
        REG_CURRENT: d.rdata = sensor_current_in;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.ref_v <= ZERO_REF_UA;
    end
    else if (ce_in)
      q <= d;
  end

  assign reg_rdata_out = q.rdata;
  assign irq_out = |(q.status & q.mask);
  assign enc_a_out = q.enc_a;
  assign enc_b_out = q.enc_b;
  assign monitor_indicator_red_out = q.led_red;
  assign monitor_indicator_blue_out = q.led_blue;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_turbine_pass: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && !analog_mode && d.blank_cnt == '0 |=> enc_a_out == $past(pins_s[PIN_TA])
      && enc_b_out == $past(pins_s[PIN_TB]))
    else $error("turbine channels not passed through");

  chk_blank_outputs: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    blanking |-> !enc_a_out && !enc_b_out)
    else $error("encoder outputs active while blanked");

  chk_range_blank: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && range_f |=> q.blank_cnt == BLANK_W'(BLANK_CYC) && monitor_indicator_red_out
      && !monitor_indicator_blue_out)
    else $error("range fault did not reload blanking with steady red");

  chk_ref_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && fall |=> q.ref_v == $past(sensor_current_in) && q.rem == REM_W'(RAMP_STEPS)
      && q.hold_cnt == HOLD_W'(HOLD_CYC))
    else $error("reference capture wrong");

  chk_ramp_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && !fall && q.hold_cnt != '0 |=> $stable(q.rem))
    else $error("ramp moved during hold time");

  chk_freq_limit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    hz_clip <= MAX_HZ[14:0] && inc_raw[27:INC_SHIFT] <= 20'(({13'h0, MAX_HZ[14:0]}
      * {15'h0, INC_MUL}) >> INC_SHIFT))
    else $error("frequency above limit");

  chk_zero_base: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dev == '0 |-> !hz_raw[23] && hz_clip == 15'(BASE_HZ))
    else $error("base frequency wrong at zero flow");

  chk_stop_time: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && stop_f |-> q.stop_cnt == STOP_W'(STOP_CYC - 1) && stop_hit)
    else $error("stop fault without full hold time");

  chk_still_flash: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && still_f && !range_f && !stop_f |=> q.flash_cause && blanking
      && (monitor_indicator_red_out != monitor_indicator_blue_out))
    else $error("standstill fault not flashing red and blue");

  chk_irq_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && range_f && q.mask[ST_RANGE] && !reg_wr_in |=> irq_out && q.status[ST_RANGE])
    else $error("unmasked range event did not raise the interrupt");

  cov_capture: cover property (@(posedge clk_sys_in) disable iff (rst_in) fall);
  cov_range: cover property (@(posedge clk_sys_in) disable iff (rst_in) range_f);
  cov_still: cover property (@(posedge clk_sys_in) disable iff (rst_in) still_f);
  cov_reverse: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    analog_mode && hz_raw[23]);
endmodule
`default_nettype wire

// *** tb_analog_flow_to_quadrature_encoder.sv ***
// Self-checking bench for the flow-to-quadrature converter.
// Assumes afq_pkg, afq_top and afq_drive_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_analog_flow_to_quadrature_encoder;
  import afq_pkg::*;
  // ****************************************************************
  // Stimulus and wiring
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic enc_err;
  logic mode_j = 1'b1;
  logic limit_j = 1'b0;
  logic tur_a = 1'b0;
  logic tur_b = 1'b0;
  logic [15:0] cur = 16'h2ee0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic press = 1'b0;
  logic driving = 1'b0;
  logic strobe;
  logic rel;
  logic [15:0] rdata;
  logic irq;
  logic enc_a;
  logic enc_b;
  logic red;
  logic blue;
  int pos;
  int n_mismatch = 0;
  int n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Short counts keep the run small; every expectation below uses these values.
  afq_top #(.HOLD_CYC(40), .STEP_CYC(2), .BLANK_CYC(50), .STOP_CYC(8), .FLASH_CYC(4)) dut_u (
    .clk_sys_in(clk_sys), .rst_in(rst), .ce_in(ce), .mode_select_jumper_in(mode_j),
    .stop_limit_jumper_in(limit_j), .zero_reference_strobe_in(strobe),
    .drive_release_input_in(rel), .turbine_a_in(tur_a), .turbine_b_in(tur_b),
    .sensor_current_in(cur), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .enc_a_out(enc_a),
    .enc_b_out(enc_b), .monitor_indicator_red_out(red), .monitor_indicator_blue_out(blue));

  afq_drive_model drive_u (
    .clk_sys_in(clk_sys), .rst_in(rst), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .pressure_reached_in(press), .driving_in(driving), .zero_reference_strobe_out(strobe),
    .drive_release_input_out(rel), .position_out(pos), .encoder_error_out(enc_err));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // Outputs are read 1 ns after an edge, once that edge's updates have landed.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_cur(input logic [15:0] v);
    @(posedge clk_sys);
    cur <= v;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_regs();
    logic [15:0] d;
    reg_read(REG_STATUS, d);
    check("status", 32'h0, d);
    reg_read(REG_MASK, d);
    check("mask", 32'h0, d);
    reg_write(REG_MASK, 16'hffff);
    reg_read(REG_MASK, d);
    check("mask", 32'hf, d);
    reg_write(REG_REF, 16'h1234);
    reg_read(REG_REF, d);
    check("reference", 32'h2ee0, d);
    reg_read(4'h7, d);
    check("unmapped", 32'h0, d);
    reg_read(REG_CURRENT, d);
    check("current", 32'h2ee0, d);
    reg_write(REG_MASK, 16'h0000);
  endtask

  task automatic test_turbine();
    logic [3:0][1:0] pat;
    pat = 8'h2d;
    @(posedge clk_sys);
    mode_j <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      tur_a <= pat[k][0];
      tur_b <= pat[k][1];
      settle(8);
      check("turbine pair", {pat[k][0], pat[k][1]}, {enc_a, enc_b});
    end
    check("encoder error", 0, enc_err);
    @(posedge clk_sys);
    mode_j <= 1'b1;
  endtask

  task automatic limit_case(input logic j, input logic [15:0] c, input int hold,
                            input logic [2:0] exp);
    logic [15:0] d;
    @(posedge clk_sys);
    limit_j <= j;
    cur <= 16'h2ee0;
    settle(10);
    reg_read(REG_STATUS, d);
    set_cur(c);
    repeat (hold) @(posedge clk_sys);
    set_cur(16'h2ee0);
    settle(4);
    reg_read(REG_STATUS, d);
    check("fault bits", exp, d[2:0]);
  endtask

  task automatic test_blank();
    logic [15:0] d;
    int i;
    reg_write(REG_MASK, 16'h0002);
    set_cur(16'h4650);
    settle(1);
    // Blanking from the quadrant with both channels high must look like a dead encoder.
    for (i = 0; i < 20000 && !(enc_a === 1'b1 && enc_b === 1'b1); i++)
      settle(1);
    if (i == 20000)
    begin
      n_mismatch++;
      $display("unexpected channel pair: expected 3, seen %0h", {enc_a, enc_b});
      end_of_test();
    end
    set_cur(16'h61a8);
    settle(3);
    check("blanked pair", 0, {enc_a, enc_b});
    check("encoder error", 1, enc_err);
    check("red", 1, red);
    check("masked irq", 0, irq);
    set_cur(16'h4650);
    reg_write(REG_MASK, 16'h0001);
    settle(2);
    check("irq", 1, irq);
    settle(25);
    check("blanked pair", 0, {enc_a, enc_b});
    set_cur(16'h61a8);
    set_cur(16'h4650);
    settle(45);
    check("restarted blank", 0, {enc_a, enc_b});
    reg_read(REG_STATUS, d);
    check("range status", 1, d[0]);
    settle(2);
    check("irq cleared", 0, irq);
    reg_write(REG_MASK, 16'h0000);
  endtask

  task automatic test_blue();
    set_cur(16'h2ee0);
    settle(60);
    check("indicator", 2'b01, {red, blue});
    set_cur(16'h2f44);
    settle(3);
    check("blue", 0, blue);
    set_cur(16'h2e7d);
    settle(3);
    check("blue", 1, blue);
  endtask

  task automatic run_dir(input logic [15:0] c, input int lo, input int hi);
    int p;
    set_cur(c);
    settle(1);
    p = pos;
    settle(20000);
    p = pos - p;
    check("position step", 1, p >= lo && p <= hi);
  endtask

  task automatic test_standstill();
    logic [15:0] d;
    logic [2:0] seen;
    seen = 3'h0;
    set_cur(16'h2c88);
    @(posedge clk_sys);
    driving <= 1'b1;
    settle(12);
    repeat (16)
    begin
      settle(1);
      seen = seen | {red, blue, red & blue};
    end
    check("flash seen", 3'b110, seen);
    check("blanked pair", 0, {enc_a, enc_b});
    reg_read(REG_STATUS, d);
    check("standstill status", 1, d[2]);
    set_cur(16'h2d50);
    settle(60);
    reg_read(REG_STATUS, d);
    settle(10);
    reg_read(REG_STATUS, d);
    check("standstill status", 0, d[2]);
    @(posedge clk_sys);
    driving <= 1'b0;
  endtask

  task automatic test_capture();
    logic [15:0] d;
    int p;
    set_cur(16'h3e80);
    settle(60);
    p = pos;
    settle(8000);
    check("flow before capture", 1, pos - p >= 2);
    reg_read(REG_STATUS, d);
    @(posedge clk_sys);
    press <= 1'b1;
    settle(10);
    reg_read(REG_REF, d);
    check("captured reference", 32'h3e80, d);
    reg_read(REG_STATUS, d);
    check("capture status", 1, d[3]);
    settle(2400);
    p = pos;
    settle(8000);
    p = pos - p;
    check("flow after fade", 1, p >= -1 && p <= 1);
    @(posedge clk_sys);
    press <= 1'b0;
  endtask

  // A low enable must freeze outputs and supervision alike.
  task automatic test_freeze();
    logic [15:0] d;
    logic [2:0] held;
    reg_read(REG_STATUS, d);
    @(posedge clk_sys);
    ce <= 1'b0;
    cur <= 16'h61a8;
    settle(1);
    held = {enc_a, enc_b, red};
    settle(20);
    check("frozen outputs", held, {enc_a, enc_b, red});
    @(posedge clk_sys);
    cur <= 16'h3e80;
    @(posedge clk_sys);
    ce <= 1'b1;
    settle(4);
    check("red after freeze", 0, red);
    reg_read(REG_STATUS, d);
    check("status after freeze", 0, d[0]);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_turbine();
    limit_case(1'b0, 16'h1a90, 14, 3'h2);
    limit_case(1'b0, 16'h1a90, 4, 3'h0);
    limit_case(1'b0, 16'h1a91, 14, 3'h0);
    limit_case(1'b0, 16'h419f, 14, 3'h0);
    limit_case(1'b0, 16'h41a0, 14, 3'h2);
    limit_case(1'b1, 16'h41a0, 14, 3'h0);
    limit_case(1'b1, 16'h138d, 14, 3'h2);
    limit_case(1'b1, 16'h138e, 14, 3'h0);
    limit_case(1'b1, 16'h4a06, 14, 3'h2);
    limit_case(1'b1, 16'h0f9f, 4, 3'h1);
    limit_case(1'b1, 16'h0fa0, 4, 3'h0);
    limit_case(1'b1, 16'h4e21, 4, 3'h1);
    limit_case(1'b1, 16'h4e20, 4, 3'h0);
    test_blank();
    test_blue();
    run_dir(16'h4650, 8, 10);
    run_dir(16'h1770, -10, -8);
    test_standstill();
    test_capture();
    test_freeze();
    end_of_test();
  end
endmodule
`default_nettype wire
